// ### tb.sv
`timescale 1ns/1ps

`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fail_count++; \
   $display("[ERR] %s exp %0h got %0h", n, e, a); end end

module tb;
   import vgdc_pkg::*;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   vgdc_req_s req;
   logic [7:0] rd_data, rd_val, cv1, cv2, cv3, cv4, glb;
   logic rd_valid;
   logic [6:0] bg, gg, rg, cg;
   logic [8:0] mixed [3];
   vgdc_cfg_s cfg;
   int fail_count = 0;
   int checked = 0;
   int cycles = 0;
   logic [7:0] vals [10] = '{8'h15, 8'h2A, 8'h3F, 8'h7F, 8'hA5, 8'h5A, 8'hFF, 8'hC3, 8'hED, 8'h96};

   vgdc_regs DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .rd_data_o(rd_data),
      .rd_valid_o(rd_valid), .blue_gain_value_o(bg), .green_gain_value_o(gg),
      .red_gain_value_o(rg), .contrast_gain_o(cg), .converter_one_code_o(cv1),
      .converter_two_code_o(cv2), .converter_three_code_o(cv3), .converter_four_code_o(cv4),
      .converter_mixed_code_o(mixed), .cfg_o(cfg), .global_video_control_o(glb));
   vgdc_host HOST (.clk_i(clk_i), .req_o(req), .rd_data_i(rd_data), .rd_valid_i(rd_valid));

   initial forever #5 clk_i = ~clk_i;

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Bound is far above the roughly 80 cycles the sequence needs
   always @(posedge clk_i) begin
      cycles++;
      if (cycles > 5000) begin
         fail_count++;
         finish_test();
      end
   end

   initial begin
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         HOST.rd(VGDC_BASE_ADDR + 16'(i), rd_val);
         `CHK("reset value", 8'h00, rd_val)
      end
      for (int i = 0; i < 10; i++) HOST.wr(VGDC_BASE_ADDR + 16'(i), vals[i]);
      HOST.wr(16'h843A, 8'h11);
      HOST.wr(16'h842F, 8'h22);
      for (int i = 0; i < 10; i++) begin
         HOST.rd(VGDC_BASE_ADDR + 16'(i), rd_val);
         `CHK("readback", (i < 4) ? (vals[i] & 8'h7F) : vals[i], rd_val)
      end
      HOST.rd(16'h843A, rd_val);
      `CHK("unmapped read", 8'h00, rd_val)
      `CHK("blue gain", 7'h15, bg)
      `CHK("green gain", 7'h2A, gg)
      `CHK("red gain", 7'h3F, rg)
      `CHK("contrast", 7'h7F, cg)
      `CHK("codes", 32'hA55AFFC3, {cv1, cv2, cv3, cv4})
      `CHK("dc offset", 3'h5, cfg.video_offset_field)
      `CHK("overlay contrast", 3'h5, cfg.overlay_contrast_field)
      `CHK("reduced range", 1'b1, cfg.reduced_range)
      `CHK("mix on", 27'h4197760, {mixed[0], mixed[1], mixed[2]})
      `CHK("global", 8'h96, glb)
      HOST.wr(VGDC_CONFIG_ADDR, 8'h12);
      @(posedge clk_i);
      #1;
      `CHK("mix off", 27'h294B4FF, {mixed[0], mixed[1], mixed[2]})
      `CHK("cfg fields", 8'h12, {cfg.mix_enable, cfg.reduced_range,
         cfg.overlay_contrast_field, cfg.video_offset_field})
      `CHK("gain kept", 7'h15, bg)
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      @(posedge clk_i);
      #1;
      `CHK("reset clears", 16'h0000, {cv4, glb})
      `CHK("blue after reset", 7'h00, bg)
      @(posedge clk_i);
      rst_n_i <= 1'b1;
      HOST.wr(VGDC_RED_GAIN_ADDR, 8'h33);
      HOST.rd(VGDC_RED_GAIN_ADDR, rd_val);
      `CHK("write after reset", 8'h33, rd_val)
      `CHK("red after reset", 7'h33, rg)
      finish_test();
   end
endmodule

// ### vgdc_host.sv
`timescale 1ns/1ps

// Host model; each request is held for exactly one taking edge
module vgdc_host
   import vgdc_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // Register port
   output vgdc_req_s req_o,
   input wire logic [7:0] rd_data_i,
   input wire logic rd_valid_i
);
   initial req_o = '0;

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_i);
      req_o <= '{1'b1, 1'b0, a, (a < VGDC_CONV_ONE_ADDR) ? (d & VGDC_GAIN_MASK) : d};
      @(posedge clk_i);
      // Released data lines show garbage, never the last byte
      req_o <= '{1'b0, 1'b0, ~a, ~d};
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      int n = 0;
      @(posedge clk_i);
      req_o <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk_i);
      req_o <= '{1'b0, 1'b0, ~a, 8'hFF};
      #1;
      while (rd_valid_i !== 1'b1 && n < 4) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      d = (rd_valid_i === 1'b1) ? rd_data_i : 8'hXX;
   endtask
endmodule

// ### vgdc_pkg.sv
package vgdc_pkg;

   localparam int unsigned VGDC_NUM_REGS = 10;
   localparam logic [15:0] VGDC_BASE_ADDR = 16'h8430;
   localparam logic [15:0] VGDC_BLUE_GAIN_ADDR = 16'h8430;
   localparam logic [15:0] VGDC_GREEN_GAIN_ADDR = 16'h8431;
   localparam logic [15:0] VGDC_RED_GAIN_ADDR = 16'h8432;
   localparam logic [15:0] VGDC_CONTRAST_ADDR = 16'h8433;
   localparam logic [15:0] VGDC_CONV_ONE_ADDR = 16'h8434;
   localparam logic [15:0] VGDC_CONV_TWO_ADDR = 16'h8435;
   localparam logic [15:0] VGDC_CONV_THREE_ADDR = 16'h8436;
   localparam logic [15:0] VGDC_CONV_FOUR_ADDR = 16'h8437;
   localparam logic [15:0] VGDC_CONFIG_ADDR = 16'h8438;
   localparam logic [15:0] VGDC_GLOBAL_ADDR = 16'h8439;

   // Register indices relative to the base address
   localparam logic [3:0] VGDC_IDX_BLUE = 4'h0;
   localparam logic [3:0] VGDC_IDX_GREEN = 4'h1;
   localparam logic [3:0] VGDC_IDX_RED = 4'h2;
   localparam logic [3:0] VGDC_IDX_CONTRAST = 4'h3;
   localparam logic [3:0] VGDC_IDX_CONV_ONE = 4'h4;
   localparam logic [3:0] VGDC_IDX_CONV_FOUR = 4'h7;
   localparam logic [3:0] VGDC_IDX_CONFIG = 4'h8;
   localparam logic [3:0] VGDC_IDX_GLOBAL = 4'h9;

   // Gain and contrast registers keep only seven bits
   localparam logic [7:0] VGDC_GAIN_MASK = 8'h7F;
   localparam logic [7:0] VGDC_FULL_MASK = 8'hFF;
   localparam logic [7:0] VGDC_REG_RESET = 8'h00;

   // Configuration register field layout
   localparam int unsigned VGDC_OFFSET_LSB = 0;
   localparam int unsigned VGDC_OVERLAY_LSB = 3;
   localparam int unsigned VGDC_RANGE_BIT = 6;
   localparam int unsigned VGDC_MIX_BIT = 7;

   typedef struct packed {
      logic wr_en;
      logic rd_en;
      logic [15:0] addr;
      logic [7:0] wdata;
   } vgdc_req_s;

   typedef struct packed {
      logic [2:0] video_offset_field;
      logic [2:0] overlay_contrast_field;
      logic reduced_range;
      logic mix_enable;
   } vgdc_cfg_s;

endpackage

// ### vgdc_regs.sv
`timescale 1ns/1ps

module vgdc_regs
   import vgdc_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Register access from the serial interface decoder
   input wire vgdc_req_s req_i,
   output logic [7:0] rd_data_o,
   output logic rd_valid_o,
   // Gain controls
   output logic [6:0] blue_gain_value_o,
   output logic [6:0] green_gain_value_o,
   output logic [6:0] red_gain_value_o,
   output logic [6:0] contrast_gain_o,
   // Converter codes, raw and after mixing
   output logic [7:0] converter_one_code_o,
   output logic [7:0] converter_two_code_o,
   output logic [7:0] converter_three_code_o,
   output logic [7:0] converter_four_code_o,
   output logic [8:0] converter_mixed_code_o [3],
   // Configuration
   output vgdc_cfg_s cfg_o,
   output logic [7:0] global_video_control_o
);

   logic [7:0] regs [VGDC_NUM_REGS];
   logic [15:0] rel_addr;
   logic [3:0] idx;
   logic hit;

   assign rel_addr = req_i.addr - VGDC_BASE_ADDR;
   assign idx = rel_addr[3:0];
   assign hit = (req_i.addr >= VGDC_BASE_ADDR) && (rel_addr < 16'(VGDC_NUM_REGS));

   // Storage: one writable byte per entry, reserved bits never stored
   generate
      for (genvar g = 0; g < VGDC_NUM_REGS; g++) begin : g_reg
         localparam logic [7:0] MASK = (g <= int'(VGDC_IDX_CONTRAST)) ? VGDC_GAIN_MASK
            : VGDC_FULL_MASK;
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               regs[g] <= VGDC_REG_RESET;
            end else if (req_i.wr_en && hit && idx == 4'(g)) begin
               regs[g] <= req_i.wdata & MASK;
            end
         end
      end
   endgenerate

   // Reads answer one cycle later; unmapped addresses read zero
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_data_o <= 8'h00;
         rd_valid_o <= 1'b0;
      end else begin
         rd_valid_o <= req_i.rd_en;
         if (req_i.rd_en) begin
            rd_data_o <= hit ? regs[idx] : 8'h00;
         end
      end
   end

   // Control outputs taken straight from the stored bytes
   always_comb begin
      blue_gain_value_o = regs[VGDC_IDX_BLUE][6:0];
      green_gain_value_o = regs[VGDC_IDX_GREEN][6:0];
      red_gain_value_o = regs[VGDC_IDX_RED][6:0];
      contrast_gain_o = regs[VGDC_IDX_CONTRAST][6:0];
      converter_one_code_o = regs[VGDC_IDX_CONV_ONE];
      converter_two_code_o = regs[VGDC_IDX_CONV_ONE + 4'h1];
      converter_three_code_o = regs[VGDC_IDX_CONV_ONE + 4'h2];
      converter_four_code_o = regs[VGDC_IDX_CONV_FOUR];
      cfg_o.video_offset_field = regs[VGDC_IDX_CONFIG][VGDC_OFFSET_LSB +: 3];
      cfg_o.overlay_contrast_field = regs[VGDC_IDX_CONFIG][VGDC_OVERLAY_LSB +: 3];
      cfg_o.reduced_range = regs[VGDC_IDX_CONFIG][VGDC_RANGE_BIT];
      cfg_o.mix_enable = regs[VGDC_IDX_CONFIG][VGDC_MIX_BIT];
      global_video_control_o = regs[VGDC_IDX_GLOBAL];
   end

   // Mixed codes carry a ninth bit so the half-scale add never wraps
   generate
      for (genvar c = 0; c < 3; c++) begin : g_mix
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               converter_mixed_code_o[c] <= 9'h000;
            end else if (regs[VGDC_IDX_CONFIG][VGDC_MIX_BIT]) begin
               converter_mixed_code_o[c] <= {1'b0, regs[int'(VGDC_IDX_CONV_ONE) + c]}
                  + {2'b00, regs[VGDC_IDX_CONV_FOUR][7:1]};
            end else begin
               converter_mixed_code_o[c] <= {1'b0, regs[int'(VGDC_IDX_CONV_ONE) + c]};
            end
         end
      end
   endgenerate

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   // Gain and contrast registers
   AST_BLUE_WRITE: assert property (
      req_i.wr_en && req_i.addr == VGDC_BLUE_GAIN_ADDR
      |=> blue_gain_value_o == $past(req_i.wdata[6:0]))
      else $error("blue gain not updated by write");
   AST_BLUE_ONLY: assert property (
      req_i.wr_en && req_i.addr == VGDC_BLUE_GAIN_ADDR
      |=> $stable(green_gain_value_o) && $stable(red_gain_value_o))
      else $error("blue gain write disturbed other channels");
   AST_GREEN_WRITE: assert property (
      req_i.wr_en && req_i.addr == VGDC_GREEN_GAIN_ADDR
      |=> green_gain_value_o == $past(req_i.wdata[6:0]))
      else $error("green gain not updated by write");
   AST_GREEN_ONLY: assert property (
      req_i.wr_en && req_i.addr == VGDC_GREEN_GAIN_ADDR
      |=> $stable(blue_gain_value_o) && $stable(red_gain_value_o))
      else $error("green gain write disturbed other channels");
   AST_RED_ONLY: assert property (
      req_i.wr_en && req_i.addr == VGDC_RED_GAIN_ADDR
      |=> red_gain_value_o == $past(req_i.wdata[6:0]) && $stable(blue_gain_value_o)
      && $stable(green_gain_value_o))
      else $error("red gain write disturbed other channels");
   AST_CONTRAST_WRITE: assert property (
      req_i.wr_en && req_i.addr == VGDC_CONTRAST_ADDR
      |=> contrast_gain_o == $past(req_i.wdata[6:0]))
      else $error("contrast not updated by write");
   AST_CONTRAST_JOINT: assert property (
      req_i.wr_en && req_i.addr == VGDC_CONTRAST_ADDR
      |=> $stable(blue_gain_value_o) && $stable(green_gain_value_o)
      && $stable(red_gain_value_o))
      else $error("contrast write disturbed channel gains");
   AST_RESERVED_ZERO: assert property (
      rd_valid_o && $past(req_i.addr) <= VGDC_CONTRAST_ADDR
      |-> rd_data_o[7] == 1'b0)
      else $error("reserved gain bit read as one");

   // Converter codes and configuration
   AST_CONV_ONE: assert property (
      req_i.wr_en && req_i.addr == VGDC_CONV_ONE_ADDR
      |=> converter_one_code_o == $past(req_i.wdata))
      else $error("converter one code not updated");
   AST_CONV_TWO: assert property (
      req_i.wr_en && req_i.addr == VGDC_CONV_TWO_ADDR
      |=> converter_two_code_o == $past(req_i.wdata))
      else $error("converter two code not updated");
   AST_CONV_THREE: assert property (
      req_i.wr_en && req_i.addr == VGDC_CONV_THREE_ADDR
      |=> converter_three_code_o == $past(req_i.wdata))
      else $error("converter three code not updated");
   AST_CONV_FOUR: assert property (
      req_i.wr_en && req_i.addr == VGDC_CONV_FOUR_ADDR
      |=> converter_four_code_o == $past(req_i.wdata))
      else $error("converter four code not updated");
   AST_CONFIG_FIELDS: assert property (
      req_i.wr_en && req_i.addr == VGDC_CONFIG_ADDR
      |=> {cfg_o.mix_enable, cfg_o.reduced_range, cfg_o.overlay_contrast_field,
      cfg_o.video_offset_field} == $past(req_i.wdata))
      else $error("config fields do not follow write");
   AST_OFFSET_FIELD: assert property (
      req_i.wr_en && req_i.addr == VGDC_CONFIG_ADDR
      |=> cfg_o.video_offset_field == $past(req_i.wdata[VGDC_OFFSET_LSB +: 3]))
      else $error("video offset field does not follow write");
   AST_OVERLAY_FIELD: assert property (
      req_i.wr_en && req_i.addr == VGDC_CONFIG_ADDR
      |=> cfg_o.overlay_contrast_field == $past(req_i.wdata[VGDC_OVERLAY_LSB +: 3]))
      else $error("overlay contrast field does not follow write");
   AST_RANGE_BIT: assert property (
      req_i.wr_en && req_i.addr == VGDC_CONFIG_ADDR
      |=> cfg_o.reduced_range == $past(req_i.wdata[VGDC_RANGE_BIT]))
      else $error("range select does not follow write");
   AST_MIX_BIT: assert property (
      req_i.wr_en && req_i.addr == VGDC_CONFIG_ADDR
      |=> cfg_o.mix_enable == $past(req_i.wdata[VGDC_MIX_BIT]))
      else $error("mix select does not follow write");

   // Mixed codes land one cycle after their source values
   AST_MIX: assert property (
      cfg_o.mix_enable
      |=> converter_mixed_code_o[0] == {1'b0, $past(converter_one_code_o)}
         + {2'b00, $past(converter_four_code_o[7:1])}
      && converter_mixed_code_o[1] == {1'b0, $past(converter_two_code_o)}
         + {2'b00, $past(converter_four_code_o[7:1])}
      && converter_mixed_code_o[2] == {1'b0, $past(converter_three_code_o)}
         + {2'b00, $past(converter_four_code_o[7:1])})
      else $error("mixed code wrong with mixing on");
   AST_NO_MIX: assert property (
      !cfg_o.mix_enable
      |=> converter_mixed_code_o[0] == {1'b0, $past(converter_one_code_o)}
      && converter_mixed_code_o[1] == {1'b0, $past(converter_two_code_o)}
      && converter_mixed_code_o[2] == {1'b0, $past(converter_three_code_o)})
      else $error("mixed code wrong with mixing off");

   // Read port, unmapped space and hold
   AST_READ_TIMING: assert property (
      req_i.rd_en |=> rd_valid_o)
      else $error("read answer missing");
   AST_READ_PULSE: assert property (
      !req_i.rd_en |=> !rd_valid_o)
      else $error("read answer without request");
   AST_READ_DATA: assert property (
      req_i.rd_en && req_i.addr == VGDC_CONV_FOUR_ADDR
      |=> rd_data_o == $past(converter_four_code_o))
      else $error("read data differs from stored code");
   AST_UNMAPPED_READ: assert property (
      req_i.rd_en && (req_i.addr < VGDC_BASE_ADDR || req_i.addr > VGDC_GLOBAL_ADDR)
      |=> rd_data_o == 8'h00)
      else $error("unmapped read returned data");
   AST_UNMAPPED_WRITE: assert property (
      req_i.wr_en && (req_i.addr < VGDC_BASE_ADDR || req_i.addr > VGDC_GLOBAL_ADDR)
      |=> $stable(blue_gain_value_o) && $stable(global_video_control_o))
      else $error("unmapped write changed a register");
   AST_GLOBAL_WRITE: assert property (
      req_i.wr_en && req_i.addr == VGDC_GLOBAL_ADDR
      |=> global_video_control_o == $past(req_i.wdata))
      else $error("global control not updated by write");
   AST_HOLD: assert property (
      !req_i.wr_en |=> $stable(blue_gain_value_o)
      && $stable(cfg_o) && $stable(converter_three_code_o))
      else $error("register changed without a write");

   COV_MIX_ON: cover property (req_i.wr_en && req_i.addr == VGDC_CONFIG_ADDR
      && req_i.wdata[VGDC_MIX_BIT]);
   COV_MIX_OFF: cover property (req_i.wr_en && req_i.addr == VGDC_CONFIG_ADDR
      && !req_i.wdata[VGDC_MIX_BIT]);
   COV_READ_BACK: cover property (req_i.wr_en ##1 req_i.rd_en ##1 rd_valid_o);
   COV_UNMAPPED: cover property (req_i.rd_en && !hit);
   COV_UNMAPPED_WRITE: cover property (req_i.wr_en
      && (req_i.addr < VGDC_BASE_ADDR || req_i.addr > VGDC_GLOBAL_ADDR));

endmodule
